// >>> common/fcsd_map.vh
// constants for the parallel flash command sequencer (host side)
// How it works
// - Each operation except read starts with its fixed address/data write sequence.
// - Apart from buffer load words, only whole table sequences are issued, in table order.
// - Reset is one write of F0 to any address, back to array read.
// - Protection verify is 555/AA, 2AA/55, 555/90, then a read at sector plus 02.
// - Secure verify uses the same three writes, then a read at offset 03.
// - Secured region entry is 555/AA, 2AA/55, 555/88; a flag records it.
// - Secured region exit is 555/AA, 2AA/55, 555/90, then 00 at a don't-care address.
// - The count word is words minus one; that many plus one loads follow.
`ifndef FCSD_MAP_VH
`define FCSD_MAP_VH

// timing
`define FCSD_CLK_PERIOD_NS 8
`define FCSD_T_CP_NS 35
`define FCSD_T_CPH_NS 30
`define FCSD_WP_CYC ((`FCSD_T_CP_NS + `FCSD_CLK_PERIOD_NS - 1) / `FCSD_CLK_PERIOD_NS)
`define FCSD_WPH_CYC ((`FCSD_T_CPH_NS + `FCSD_CLK_PERIOD_NS - 1) / `FCSD_CLK_PERIOD_NS)

// unlock addresses
`define FCSD_ADDR_UNLOCK1 11'h555
`define FCSD_ADDR_UNLOCK2 11'h2AA

// command bytes
`define FCSD_D_UNLOCK1 8'hAA
`define FCSD_D_UNLOCK2 8'h55
`define FCSD_D_AUTOSEL 8'h90
`define FCSD_D_RESET 8'hF0
`define FCSD_D_PROGRAM 8'hA0
`define FCSD_D_WBUF 8'h25
`define FCSD_D_CONFIRM 8'h29
`define FCSD_D_UB_ENTER 8'h20
`define FCSD_D_ERASE_SETUP 8'h80
`define FCSD_D_SECTOR_ERASE 8'h30
`define FCSD_D_CHIP_ERASE 8'h10
`define FCSD_D_EXIT 8'h00
`define FCSD_D_SUSPEND 8'hB0
`define FCSD_D_RESUME 8'h30
`define FCSD_D_SECSI 8'h88

// user operation codes
`define FCSD_OP_READ 5'h00
`define FCSD_OP_RESET 5'h01
`define FCSD_OP_AUTOSEL 5'h02
`define FCSD_OP_PROGRAM 5'h03
`define FCSD_OP_WBUF 5'h04
`define FCSD_OP_CONFIRM 5'h05
`define FCSD_OP_ABORT 5'h06
`define FCSD_OP_UB_ENTER 5'h07
`define FCSD_OP_UB_PROG 5'h08
`define FCSD_OP_UB_SERASE 5'h09
`define FCSD_OP_UB_CERASE 5'h0A
`define FCSD_OP_UB_RESET 5'h0B
`define FCSD_OP_CHIP_ERASE 5'h0C
`define FCSD_OP_SECTOR_ERASE 5'h0D
`define FCSD_OP_SUSPEND 5'h0E
`define FCSD_OP_RESUME 5'h0F
`define FCSD_OP_SECSI_ENTER 5'h10
`define FCSD_OP_SECSI_EXIT 5'h11

// step word fields: {last, read, asel[1:0], dsel[1:0], byte[7:0]}
`define FCSD_ST_LAST 13
`define FCSD_ST_RD 12
`define FCSD_ST_ASEL_HI 11
`define FCSD_ST_ASEL_LO 10
`define FCSD_ST_DSEL_HI 9
`define FCSD_ST_DSEL_LO 8
`define FCSD_ST_BYTE_HI 7
`define FCSD_ST_BYTE_LO 0

// address select
`define FCSD_AS_U1 2'h0
`define FCSD_AS_U2 2'h1
`define FCSD_AS_USER 2'h2
`define FCSD_AS_X 2'h3
// data select
`define FCSD_DS_BYTE 2'h0
`define FCSD_DS_USER 2'h1
`define FCSD_DS_COUNT 2'h2

`endif

// >>> hw/fcsd_bus_cycle.v
// one asynchronous flash bus cycle, write or read, with pin timing
`timescale 1ns/1ps
`include "fcsd_map.vh"
module fcsd_bus_cycle #(
  parameter AW = 24,
  parameter DW = 16,
  parameter T_ACC_NS = 100
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // cycle request
  input wire start,
  input wire is_read,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg done_ff,
  output reg [DW-1:0] rdata_ff,
  // flash pins
  output reg [AW-1:0] flash_addr_ff,
  output reg [DW-1:0] flash_dq_o_ff,
  output reg flash_dq_oe_ff,
  input wire [DW-1:0] flash_dq_i,
  output reg flash_ce_n_ff,
  output reg flash_oe_n_ff,
  output reg flash_we_n_ff
);
  localparam integer RD_CYC = (T_ACC_NS + `FCSD_CLK_PERIOD_NS - 1) / `FCSD_CLK_PERIOD_NS;
  localparam integer RD_M1 = RD_CYC - 1;
  localparam integer WP_M1 = `FCSD_WP_CYC - 1;
  localparam integer WPH_M1 = `FCSD_WPH_CYC - 1;
  localparam [4:0] RD_CNT = RD_M1[4:0];
  localparam [4:0] WP_CNT = WP_M1[4:0];
  localparam [4:0] WPH_CNT = WPH_M1[4:0];
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SETUP = 5'h02;
  localparam [4:0] S_ACT = 5'h04;
  localparam [4:0] S_HOLD = 5'h08;
  localparam [4:0] S_GAP = 5'h10;

  reg [4:0] st_ff;
  reg [4:0] cnt_ff;
  reg rd_ff;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      cnt_ff <= 5'h00;
      rd_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= {DW{1'b0}};
      flash_addr_ff <= {AW{1'b0}};
      flash_dq_o_ff <= {DW{1'b0}};
      flash_dq_oe_ff <= 1'b0;
      flash_ce_n_ff <= 1'b1;
      flash_oe_n_ff <= 1'b1;
      flash_we_n_ff <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (start) begin
            // address, data and chip enable settle a cycle before flash_we_n or flash_oe_n moves
            flash_addr_ff <= addr;
            flash_dq_o_ff <= wdata;
            flash_dq_oe_ff <= ~is_read;
            rd_ff <= is_read;
            flash_ce_n_ff <= 1'b0;
            st_ff <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (rd_ff) begin
            flash_oe_n_ff <= 1'b0;
            cnt_ff <= RD_CNT;
          end else begin
            flash_we_n_ff <= 1'b0;
            cnt_ff <= WP_CNT;
          end
          st_ff <= S_ACT;
        end
        S_ACT: begin
          if (cnt_ff == 5'h00) begin
            if (rd_ff) begin
              rdata_ff <= flash_dq_i;
              flash_oe_n_ff <= 1'b1;
            end else begin
              flash_we_n_ff <= 1'b1;
            end
            st_ff <= S_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 5'h01;
          end
        end
        S_HOLD: begin
          // data kept one cycle past the strobe rise
          flash_ce_n_ff <= 1'b1;
          flash_dq_oe_ff <= 1'b0;
          cnt_ff <= WPH_CNT;
          st_ff <= S_GAP;
        end
        S_GAP: begin
          if (cnt_ff == 5'h00) begin
            done_ff <= 1'b1;
            st_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 5'h01;
          end
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> hw/fcsd_host.v
// host-side command sequencer driving a parallel nor flash in x16 mode
`timescale 1ns/1ps
`include "fcsd_map.vh"
module fcsd_host #(
  parameter AW = 24,
  parameter DW = 16,
  parameter CW = 5,
  parameter T_ACC_NS = 100
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // operation request
  input wire cmd_valid,
  input wire [4:0] cmd_op,
  input wire [AW-1:0] cmd_addr,
  input wire [DW-1:0] cmd_data,
  input wire [CW-1:0] cmd_count,
  output reg cmd_ready_ff,
  output reg cmd_err_ff,
  // read answer
  output reg rd_valid_ff,
  output reg [DW-1:0] rd_data_ff,
  // buffer load words
  input wire load_valid,
  input wire [AW-1:0] load_addr,
  input wire [DW-1:0] load_data,
  output reg load_ready_ff,
  // mode status
  input wire erase_done,
  output reg bypass_ff,
  output reg erase_ff,
  output reg susp_ff,
  output reg secsi_ff,
  output reg autosel_ff,
  // flash pins
  output wire [AW-1:0] flash_addr,
  output wire [DW-1:0] flash_dq_o,
  output wire flash_dq_oe,
  input wire [DW-1:0] flash_dq_i,
  output wire flash_ce_n,
  output wire flash_oe_n,
  output wire flash_we_n
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ISSUE = 5'h02;
  localparam [4:0] S_WAIT = 5'h04;
  localparam [4:0] S_LOAD = 5'h08;
  localparam [4:0] S_LWAIT = 5'h10;

  reg [4:0] st_ff;
  reg [4:0] op_ff;
  reg [AW-1:0] addr_ff;
  reg [DW-1:0] data_ff;
  reg [CW-1:0] count_ff;
  reg [CW-1:0] left_ff;
  reg [2:0] idx_ff;
  reg start_ff;
  reg cyc_rd_ff;
  reg [AW-1:0] cyc_addr_ff;
  reg [DW-1:0] cyc_data_ff;
  wire cyc_done;
  wire [DW-1:0] cyc_rdata;

  function [13:0] mk;
    input l;
    input r;
    input [1:0] a;
    input [1:0] d;
    input [7:0] b;
    begin
      mk = {l, r, a, d, b};
    end
  endfunction

  // step table: every sequence the host issues
  function [13:0] step;
    input [4:0] op;
    input [2:0] idx;
    reg [13:0] u1;
    reg [13:0] u2;
    begin
      u1 = mk(1'b0, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE, `FCSD_D_UNLOCK1);
      u2 = mk(1'b0, 1'b0, `FCSD_AS_U2, `FCSD_DS_BYTE, `FCSD_D_UNLOCK2);
      step = mk(1'b1, 1'b1, `FCSD_AS_USER, `FCSD_DS_BYTE, 8'h00);
      case (op)
        `FCSD_OP_RESET: step = mk(1'b1, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_RESET);
        `FCSD_OP_CONFIRM:
          step = mk(1'b1, 1'b0, `FCSD_AS_USER, `FCSD_DS_BYTE, `FCSD_D_CONFIRM);
        `FCSD_OP_SUSPEND:
          step = mk(1'b1, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_SUSPEND);
        `FCSD_OP_RESUME: step = mk(1'b1, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_RESUME);
        `FCSD_OP_UB_PROG: step = (idx == 3'h0) ?
          mk(1'b0, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_PROGRAM) :
          mk(1'b1, 1'b0, `FCSD_AS_USER, `FCSD_DS_USER, 8'h00);
        `FCSD_OP_UB_SERASE: step = (idx == 3'h0) ?
          mk(1'b0, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_ERASE_SETUP) :
          mk(1'b1, 1'b0, `FCSD_AS_USER, `FCSD_DS_BYTE, `FCSD_D_SECTOR_ERASE);
        `FCSD_OP_UB_CERASE: step = (idx == 3'h0) ?
          mk(1'b0, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_ERASE_SETUP) :
          mk(1'b1, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_CHIP_ERASE);
        `FCSD_OP_UB_RESET: step = (idx == 3'h0) ?
          mk(1'b0, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_AUTOSEL) :
          mk(1'b1, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_EXIT);
        `FCSD_OP_READ: step = mk(1'b1, 1'b1, `FCSD_AS_USER, `FCSD_DS_BYTE, 8'h00);
        default: begin
          // all remaining operations open with the two unlock writes
          case (idx)
            3'h0: step = u1;
            3'h1: step = u2;
            3'h2: begin
              case (op)
                `FCSD_OP_AUTOSEL: step = mk(1'b0, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_AUTOSEL);
                `FCSD_OP_SECSI_EXIT: step = mk(1'b0, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_AUTOSEL);
                `FCSD_OP_PROGRAM: step = mk(1'b0, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_PROGRAM);
                `FCSD_OP_WBUF: step = mk(1'b0, 1'b0, `FCSD_AS_USER, `FCSD_DS_BYTE,
                  `FCSD_D_WBUF);
                `FCSD_OP_ABORT: step = mk(1'b1, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_RESET);
                `FCSD_OP_UB_ENTER: step = mk(1'b1, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_UB_ENTER);
                `FCSD_OP_SECSI_ENTER: step = mk(1'b1, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_SECSI);
                default: step = mk(1'b0, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE,
                  `FCSD_D_ERASE_SETUP);
              endcase
            end
            3'h3: begin
              case (op)
                `FCSD_OP_AUTOSEL:
                  step = mk(1'b1, 1'b1, `FCSD_AS_USER, `FCSD_DS_BYTE, 8'h00);
                `FCSD_OP_SECSI_EXIT:
                  step = mk(1'b1, 1'b0, `FCSD_AS_X, `FCSD_DS_BYTE, `FCSD_D_EXIT);
                `FCSD_OP_PROGRAM:
                  step = mk(1'b1, 1'b0, `FCSD_AS_USER, `FCSD_DS_USER, 8'h00);
                `FCSD_OP_WBUF:
                  step = mk(1'b1, 1'b0, `FCSD_AS_USER, `FCSD_DS_COUNT, 8'h00);
                default: step = u1;
              endcase
            end
            3'h4: step = u2;
            default: begin
              if (op == `FCSD_OP_CHIP_ERASE)
                step = mk(1'b1, 1'b0, `FCSD_AS_U1, `FCSD_DS_BYTE, `FCSD_D_CHIP_ERASE);
              else
                step = mk(1'b1, 1'b0, `FCSD_AS_USER, `FCSD_DS_BYTE,
                  `FCSD_D_SECTOR_ERASE);
            end
          endcase
        end
      endcase
    end
  endfunction

  wire [13:0] cur = step(op_ff, idx_ff);
  wire [1:0] asel = cur[`FCSD_ST_ASEL_HI:`FCSD_ST_ASEL_LO];
  wire [1:0] dsel = cur[`FCSD_ST_DSEL_HI:`FCSD_ST_DSEL_LO];
  reg [AW-1:0] step_addr;
  reg [DW-1:0] step_data;

  always @* begin
    case (asel)
      `FCSD_AS_U1: step_addr = {{(AW-11){1'b0}}, `FCSD_ADDR_UNLOCK1};
      `FCSD_AS_U2: step_addr = {{(AW-11){1'b0}}, `FCSD_ADDR_UNLOCK2};
      `FCSD_AS_USER: step_addr = addr_ff;
      default: step_addr = {AW{1'b0}};
    endcase
    case (dsel)
      `FCSD_DS_USER: step_data = data_ff;
      `FCSD_DS_COUNT: step_data = {{(DW-CW){1'b0}}, count_ff};
      default: step_data = {{(DW-8){1'b0}}, cur[`FCSD_ST_BYTE_HI:`FCSD_ST_BYTE_LO]};
    endcase
  end

  // ops the flash would refuse in this mode
  reg refuse;
  always @* begin
    case (cmd_op)
      `FCSD_OP_UB_PROG, `FCSD_OP_UB_SERASE, `FCSD_OP_UB_CERASE, `FCSD_OP_UB_RESET:
        refuse = ~bypass_ff;
      `FCSD_OP_SUSPEND: refuse = ~erase_ff | susp_ff;
      `FCSD_OP_RESUME: refuse = ~susp_ff;
      default: refuse = (cmd_op > `FCSD_OP_SECSI_EXIT);
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      op_ff <= `FCSD_OP_READ;
      addr_ff <= {AW{1'b0}};
      data_ff <= {DW{1'b0}};
      count_ff <= {CW{1'b0}};
      left_ff <= {CW{1'b0}};
      idx_ff <= 3'h0;
      start_ff <= 1'b0;
      cyc_rd_ff <= 1'b0;
      cyc_addr_ff <= {AW{1'b0}};
      cyc_data_ff <= {DW{1'b0}};
      cmd_ready_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= {DW{1'b0}};
      load_ready_ff <= 1'b0;
      bypass_ff <= 1'b0;
      erase_ff <= 1'b0;
      susp_ff <= 1'b0;
      secsi_ff <= 1'b0;
      autosel_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      cmd_err_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      // an erase finishing never clears a flag set in the same cycle below
      if (erase_done) begin
        erase_ff <= 1'b0;
        susp_ff <= 1'b0;
      end
      case (st_ff)
        S_IDLE: begin
          cmd_ready_ff <= 1'b1;
          if (cmd_valid && cmd_ready_ff) begin
            if (refuse) begin
              cmd_err_ff <= 1'b1;
            end else begin
              op_ff <= cmd_op;
              addr_ff <= cmd_addr;
              data_ff <= cmd_data;
              count_ff <= cmd_count;
              idx_ff <= 3'h0;
              cmd_ready_ff <= 1'b0;
              st_ff <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          cyc_rd_ff <= cur[`FCSD_ST_RD];
          cyc_addr_ff <= step_addr;
          cyc_data_ff <= step_data;
          start_ff <= 1'b1;
          st_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (cur[`FCSD_ST_RD]) begin
              rd_data_ff <= cyc_rdata;
              rd_valid_ff <= 1'b1;
            end
            if (cur[`FCSD_ST_LAST]) begin
              case (op_ff)
                `FCSD_OP_RESET: autosel_ff <= 1'b0;
                `FCSD_OP_AUTOSEL: autosel_ff <= 1'b1;
                `FCSD_OP_UB_ENTER: bypass_ff <= 1'b1;
                `FCSD_OP_UB_RESET: bypass_ff <= 1'b0;
                `FCSD_OP_SECTOR_ERASE, `FCSD_OP_UB_SERASE: erase_ff <= 1'b1;
                `FCSD_OP_SUSPEND: susp_ff <= 1'b1;
                `FCSD_OP_RESUME: susp_ff <= 1'b0;
                `FCSD_OP_SECSI_ENTER: secsi_ff <= 1'b1;
                `FCSD_OP_SECSI_EXIT: secsi_ff <= 1'b0;
                default: begin
                end
              endcase
              if (op_ff == `FCSD_OP_WBUF) begin
                left_ff <= count_ff;
                load_ready_ff <= 1'b1;
                st_ff <= S_LOAD;
              end else begin
                cmd_ready_ff <= 1'b1;
                st_ff <= S_IDLE;
              end
            end else begin
              idx_ff <= idx_ff + 3'h1;
              st_ff <= S_ISSUE;
            end
          end
        end
        S_LOAD: begin
          if (load_valid && load_ready_ff) begin
            load_ready_ff <= 1'b0;
            cyc_rd_ff <= 1'b0;
            cyc_addr_ff <= load_addr;
            cyc_data_ff <= load_data;
            start_ff <= 1'b1;
            st_ff <= S_LWAIT;
          end
        end
        S_LWAIT: begin
          if (cyc_done) begin
            if (left_ff == {CW{1'b0}}) begin
              cmd_ready_ff <= 1'b1;
              st_ff <= S_IDLE;
            end else begin
              left_ff <= left_ff - {{(CW-1){1'b0}}, 1'b1};
              load_ready_ff <= 1'b1;
              st_ff <= S_LOAD;
            end
          end
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end

  fcsd_bus_cycle #(
    .AW(AW),
    .DW(DW),
    .T_ACC_NS(T_ACC_NS)
  ) u_cycle (
    .clk(clk),
    .rstn(rstn),
    .start(start_ff),
    .is_read(cyc_rd_ff),
    .addr(cyc_addr_ff),
    .wdata(cyc_data_ff),
    .done_ff(cyc_done),
    .rdata_ff(cyc_rdata),
    .flash_addr_ff(flash_addr),
    .flash_dq_o_ff(flash_dq_o),
    .flash_dq_oe_ff(flash_dq_oe),
    .flash_dq_i(flash_dq_i),
    .flash_ce_n_ff(flash_ce_n),
    .flash_oe_n_ff(flash_oe_n),
    .flash_we_n_ff(flash_we_n)
  );
endmodule

// >>> verif/fcsd_flash_model.sv
// behavioural x16 parallel nor flash, command decode only
`timescale 1ns/1ps
module fcsd_flash_model #(
  // id and status words: arbitrary values
  parameter [15:0] MFR_CODE = 16'h00C3,
  parameter [15:0] DEV1_CODE = 16'h1A2B,
  parameter [15:0] DEV2_CODE = 16'h0C0D,
  parameter [15:0] DEV3_CODE = 16'h0E0F,
  parameter [15:0] PROT_STATE = 16'h0001,
  parameter [15:0] SECSI_IND = 16'h0080
) (
  // flash pins
  input wire [23:0] flash_addr,
  input wire [15:0] flash_dq_o,
  input wire flash_dq_oe,
  output wire [15:0] flash_dq_i,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n
);
  reg [15:0] arr [0:255];
  reg [15:0] sec [0:255];
  reg [7:0] bpa [0:31];
  reg [15:0] bpd [0:31];
  reg [23:0] a_lat;
  reg [15:0] q, last;
  reg [3:0] cyc;
  reg [4:0] wc, n;
  reg armed, asel, secsi, byp, ers_arm, ers, susp;
  integer i;
  wire wr_n = flash_we_n | flash_ce_n;
  wire [7:0] d = flash_dq_o[7:0];
  wire [10:0] a11 = a_lat[10:0];
  wire [7:0] ix = a_lat[7:0];
  function [15:0] idw(input [7:0] o);
    case (o)
      8'h00: idw = MFR_CODE;
      8'h01: idw = DEV1_CODE;
      8'h0E: idw = DEV2_CODE;
      8'h0F: idw = DEV3_CODE;
      8'h02: idw = PROT_STATE;
      8'h03: idw = SECSI_IND;
      default: idw = 16'h0000;
    endcase
  endfunction
  initial begin
    for (i = 0; i < 256; i = i + 1) begin
      arr[i] = 16'hFFFF;
      sec[i] = 16'hFFFF;
    end
    {armed, asel, secsi, byp, ers_arm, ers, susp} = 7'h00;
    cyc = 4'h0;
    last = 16'h0000;
  end
  always @(negedge wr_n) begin
    a_lat = flash_addr;
    armed = 1'b1;
  end
  // power-up x to 1 is also a rising edge, hence the arming
  always @(posedge wr_n) begin
    if (armed) begin
      armed = 1'b0;
      if (d == 8'hF0) begin
        cyc = 4'h0;
        asel = 1'b0;
      end else case (cyc)
        4'h0: if (d == 8'hAA && a11 == 11'h555) cyc = 4'h1;
          else if (byp && d == 8'hA0) cyc = 4'h4;
          else if (byp && d == 8'h90) cyc = 4'h9;
          else if (d == 8'hB0 && ers) susp = 1'b1;
          else if (d == 8'h30) susp = 1'b0;
        4'h1: cyc = (d == 8'h55 && a11 == 11'h2AA) ? 4'h2 : 4'h0;
        4'h2: begin
          cyc = 4'h0;
          case (d)
            8'h90: {asel, cyc} = {1'b1, 4'h3};
            8'h88: secsi = 1'b1;
            8'hA0: cyc = 4'h4;
            8'h25: cyc = 4'h5;
            8'h20: byp = 1'b1;
            8'h80: ers_arm = 1'b1;
            8'h30: {ers, ers_arm} = {ers_arm, 1'b0};
            default: ers_arm = 1'b0;
          endcase
        end
        4'h3: begin
          if (d == 8'h00) {secsi, asel} = 2'b00;
          cyc = (d == 8'hAA && a11 == 11'h555) ? 4'h1 : 4'h0;
        end
        4'h4: begin
          if (secsi) sec[ix] = flash_dq_o;
          else arr[ix] = flash_dq_o;
          cyc = 4'h0;
        end
        4'h5: {wc, n, cyc} = {flash_dq_o[4:0], 5'h00, 4'h6};
        4'h6: begin
          bpa[n] = ix;
          bpd[n] = flash_dq_o;
          if (n == wc) cyc = 4'h7;
          n = n + 5'h01;
        end
        4'h7: begin
          if (d == 8'h29) for (i = 0; i <= wc; i = i + 1) arr[bpa[i]] = bpd[i];
          cyc = 4'h0;
        end
        4'h9: {byp, cyc} = {(d != 8'h00) & byp, 4'h0};
        default: cyc = 4'h0;
      endcase
    end
  end
  // released bus shows the inverse, never a stale word
  always @* begin
    if (!flash_ce_n && !flash_oe_n) begin
      q = asel ? idw(flash_addr[7:0]) : secsi ? sec[flash_addr[7:0]] : arr[flash_addr[7:0]];
      last = q;
    end else q = ~last;
  end
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : q;
endmodule

// >>> verif/fcsd_host_asserts.sv
// concurrent checks on the flash sequencer's command port and flash pins
`timescale 1ns/1ps
module fcsd_host_asserts #(
  parameter AW = 24,
  parameter DW = 16
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // command port
  input wire cmd_valid,
  input wire [4:0] cmd_op,
  input wire cmd_ready_ff,
  input wire cmd_err_ff,
  input wire rd_valid_ff,
  // mode flags
  input wire bypass_ff,
  input wire erase_ff,
  input wire autosel_ff,
  // flash pins
  input wire [AW-1:0] flash_addr,
  input wire [DW-1:0] flash_dq_o,
  input wire flash_dq_oe,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire take = cmd_valid && cmd_ready_ff;

  AST_WE_DRIVES: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
    else $error("bad write strobe");
  AST_OE_NO_DRIVE: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("data driven in read");
  AST_ADDR_HELD: assert property (!flash_we_n |-> $stable(flash_addr))
    else $error("address moved");
  AST_DATA_HELD: assert property ($rose(flash_we_n) |-> $stable(flash_dq_o) && flash_dq_oe)
    else $error("data not held");
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
    else $error("write width");
  AST_UNLOCK_LOW_BYTE: assert property (!flash_we_n && flash_addr[11:0] == 12'h555
    |-> flash_dq_o[15:8] == 8'h00)
    else $error("upper byte set");
  AST_READ_WIDTH: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8])
    else $error("read too short");
  AST_BAD_OP: assert property (take && cmd_op > 5'h11 |=> cmd_err_ff && cmd_ready_ff)
    else $error("bad op taken");
  AST_SUSP_REFUSE: assert property (take && cmd_op == 5'h0E && !erase_ff |=> cmd_err_ff)
    else $error("suspend taken");
  AST_UB_REFUSE: assert property (take && cmd_op >= 5'h08 && cmd_op <= 5'h0B && !bypass_ff
    |=> cmd_err_ff)
    else $error("bypass op taken");
  AST_RESET_OP: assert property (take && cmd_op == 5'h01 |=> !cmd_ready_ff ##[2:5]
    (!flash_we_n && flash_dq_o == 16'h00F0) ##[4:14] (cmd_ready_ff && !autosel_ff))
    else $error("reset sequence");
  AST_RD_WITH_READY: assert property (rd_valid_ff |-> cmd_ready_ff)
    else $error("read while busy");
endmodule
bind fcsd_host fcsd_host_asserts #(.AW(AW), .DW(DW)) u_chk (.*);

// >>> verif/tb_top.sv
// self-checking bench: sequencer against a behavioural flash
`timescale 1ns/1ps
`include "fcsd_map.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin n_errors = n_errors + 1; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  // id words: arbitrary values
  localparam [15:0] MFR = 16'h00C3;
  localparam [15:0] DV1 = 16'h1A2B;
  localparam [15:0] DV2 = 16'h0C0D;
  localparam [15:0] DV3 = 16'h0E0F;
  localparam [15:0] PROT = 16'h0001;
  localparam [15:0] SIND = 16'h0080;
  reg clk, rstn, cmd_valid, load_valid, erase_done, err;
  reg [4:0] cmd_op, cmd_count, cnt;
  reg [23:0] cmd_addr, load_addr, a;
  reg [15:0] cmd_data, load_data, d, rd;
  reg [15:0] shm [0:255];
  wire cmd_ready_ff, cmd_err_ff, rd_valid_ff, load_ready_ff, flash_dq_oe;
  wire bypass_ff, erase_ff, susp_ff, secsi_ff, autosel_ff, flash_ce_n, flash_oe_n, flash_we_n;
  wire [15:0] rd_data_ff, flash_dq_o, flash_dq_i;
  wire [23:0] flash_addr;
  integer n_errors, n_checks, i, j;
  fcsd_host DUT (.*);
  fcsd_flash_model #(.MFR_CODE(MFR), .DEV1_CODE(DV1), .DEV2_CODE(DV2), .DEV3_CODE(DV3),
    .PROT_STATE(PROT), .SECSI_IND(SIND)) u_flash (.*);
  function [15:0] exp_id(input [7:0] o);
    case (o)
      8'h00: exp_id = MFR;
      8'h01: exp_id = DV1;
      8'h0E: exp_id = DV2;
      8'h0F: exp_id = DV3;
      8'h02: exp_id = PROT;
      default: exp_id = SIND;
    endcase
  endfunction
  // 0..5 map to offsets 00 01 0E 0F 02 03
  function [7:0] id_off(input integer k);
    id_off = (k < 2) ? k[7:0] : (k < 4) ? k[7:0] + 8'h0C : k[7:0] - 8'h02;
  endfunction
  task complete_run;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task bound(input integer k);
    if (k >= 2000) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  endtask
  task issue(input [4:0] o, input [23:0] ad, input [15:0] dt, input [4:0] c);
    integer k;
    begin
      {cmd_valid, cmd_op, cmd_addr, cmd_data, cmd_count} <= {1'b1, o, ad, dt, c};
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (!cmd_ready_ff && k < 2000);
      bound(k);
      cmd_valid <= 1'b0;
    end
  endtask
  task fin;
    integer k;
    begin
      {err, rd, k} = 0;
      do begin
        @(posedge clk);
        if (cmd_err_ff) err = 1'b1;
        if (rd_valid_ff) rd = rd_data_ff;
        k = k + 1;
      end while (!cmd_ready_ff && k < 2000);
      bound(k);
    end
  endtask
  task op(input [4:0] o, input [23:0] ad, input [15:0] dt);
    begin
      issue(o, ad, dt, 5'h00);
      fin;
    end
  endtask
  // load_valid stays high between words, the caller drops it
  task ld(input [23:0] ad, input [15:0] dt);
    integer k;
    begin
      {load_valid, load_addr, load_data} <= {1'b1, ad, dt};
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (!load_ready_ff && k < 2000);
      bound(k);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {n_errors, n_checks} = 0;
    {rstn, cmd_valid, load_valid, erase_done, cmd_op, cmd_count} = 0;
    {cmd_addr, load_addr, cmd_data, load_data} = 0;
    for (i = 0; i < 256; i = i + 1) shm[i] = 16'hFFFF;
    void'($urandom(32'h3BCC3D9C));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({bypass_ff, erase_ff, susp_ff, secsi_ff, autosel_ff}, 5'h00)
    `CHK({flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe}, 4'hE)
    for (i = 0; i < 8; i = i + 1) begin
      a = {16'h0100, 8'($urandom)};
      d = (i == 0) ? 16'h0000 : 16'($urandom);
      op(`FCSD_OP_PROGRAM, a, d);
      shm[a[7:0]] = d;
      op(`FCSD_OP_READ, a, 16'h0000);
      `CHK(rd, shm[a[7:0]])
    end
    for (j = 0; j < 6; j = j + 1) begin
      op((j == 0) ? `FCSD_OP_AUTOSEL : `FCSD_OP_READ, {16'h0500, id_off(j)}, 16'h0000);
      `CHK(rd, exp_id(id_off(j)))
    end
    `CHK(autosel_ff, 1'b1)
    op(`FCSD_OP_RESET, 24'h000000, 16'h0000);
    op(`FCSD_OP_READ, a, 16'h0000);
    `CHK({autosel_ff, rd}, {1'b0, shm[a[7:0]]})
    op(`FCSD_OP_SECSI_ENTER, 24'h000000, 16'h0000);
    op(`FCSD_OP_PROGRAM, a, ~shm[a[7:0]]);
    op(`FCSD_OP_READ, a, 16'h0000);
    `CHK({secsi_ff, rd}, {1'b1, ~shm[a[7:0]]})
    op(`FCSD_OP_SECSI_EXIT, 24'h000000, 16'h0000);
    op(`FCSD_OP_READ, a, 16'h0000);
    `CHK({secsi_ff, rd}, {1'b0, shm[a[7:0]]})
    for (j = 0; j < 3; j = j + 1) begin
      cnt = (j == 0) ? 5'h00 : (j == 1) ? 5'($urandom_range(30, 1)) : 5'h1F;
      issue(`FCSD_OP_WBUF, 24'h020000, 16'h0000, cnt);
      for (i = 0; i <= cnt; i = i + 1) begin
        d = 16'($urandom);
        ld({16'h0200, 8'h80 + i[7:0]}, d);
        shm[8'h80 + i[7:0]] = d;
      end
      load_valid <= 1'b0;
      fin;
      op(`FCSD_OP_CONFIRM, 24'h020000, 16'h0000);
      for (i = 0; i <= cnt; i = i + 1) begin
        op(`FCSD_OP_READ, {16'h0200, 8'h80 + i[7:0]}, 16'h0000);
        `CHK(rd, shm[8'h80 + i[7:0]])
      end
    end
    for (j = 8; j < 32; j = j + 1) begin
      if (j < 12 || j == 14 || j == 15 || j > 17) begin
        op(j[4:0], 24'h020000, 16'h0000);
        `CHK(err, 1'b1)
      end
    end
    op(`FCSD_OP_UB_ENTER, 24'h000000, 16'h0000);
    `CHK(bypass_ff, 1'b1)
    op(`FCSD_OP_UB_PROG, 24'h010042, 16'hC35A);
    shm[8'h42] = 16'hC35A;
    op(`FCSD_OP_UB_SERASE, 24'h030000, 16'h0000);
    op(`FCSD_OP_UB_CERASE, 24'h000000, 16'h0000);
    `CHK(err, 1'b0)
    op(`FCSD_OP_UB_RESET, 24'h000000, 16'h0000);
    op(`FCSD_OP_READ, 24'h010042, 16'h0000);
    `CHK({bypass_ff, rd}, {1'b0, shm[8'h42]})
    op(`FCSD_OP_SECTOR_ERASE, 24'h030000, 16'h0000);
    op(`FCSD_OP_SUSPEND, 24'h000000, 16'h0000);
    `CHK({err, erase_ff, susp_ff}, 3'b011)
    op(`FCSD_OP_SUSPEND, 24'h000000, 16'h0000);
    `CHK(err, 1'b1)
    op(`FCSD_OP_RESUME, 24'h000000, 16'h0000);
    `CHK({err, susp_ff}, 2'b00)
    erase_done <= 1'b1;
    @(posedge clk);
    erase_done <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(erase_ff, 1'b0)
    op(`FCSD_OP_ABORT, 24'h000000, 16'h0000);
    op(`FCSD_OP_CHIP_ERASE, 24'h000000, 16'h0000);
    `CHK(err, 1'b0)
    complete_run;
  end
endmodule
